// File: rtl/serial_port_interface_config.sv
// Serial control port with its interface configuration registers.
// Assumes an external host drives SCLK, CS_N and SDIO; SCLK only runs
// while CS_N is low. Frame: R/W flag, 15 address bits, data bytes.
// Operation
// - Bit 3 set: read data on SDO
// - Streaming address up if bit 2, else down
// - Bit 1 set: shift LSB first
// - Soft reset bit self-clears after reset
// - Bits 7..4 mirror bits 0..3
`timescale 1ns/1ps
module serial_port_interface_config
  import spi_cfg_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDIO_IN,
  output logic SDIO_OUT,
  output logic SDIO_OE,
  output logic SDO,
  output logic SDO_OE,
  output logic SOFT_RESET_ACTIVE
);
  // Link-domain reset: chip reset or idle chip select
  logic link_rst_n;
  assign link_rst_n = RST_N & ~CS_N;

  // Control bits, held in the CLK domain
  logic [3:0] ctrl_q;
  logic [3:0] ctrl_d;
  logic [1:0] cfg_b_q;
  logic [1:0] cfg_b_d;
  logic [3:0] rst_cnt_q;
  logic [3:0] rst_cnt_d;

  // Link domain state
  link_state_t state_q;
  link_state_t state_d;
  logic [4:0] bit_cnt_q;
  logic [4:0] bit_cnt_d;
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic read_q;
  logic read_d;
  logic [14:0] addr_q;
  logic [14:0] addr_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic wr_tog_q;
  logic wr_tog_d;
  logic [14:0] wr_addr_q;
  logic [14:0] wr_addr_d;
  logic [7:0] wr_data_q;
  logic [7:0] wr_data_d;

  // Link copy of the control bits, captured at the first rise of each frame.
  // A write to them takes effect from the next frame, so the bit order and
  // wire mode never change in mid-frame and the copy is taken while static.
  logic [3:0] lnk_ctrl_q;
  logic [3:0] lnk_ctrl_d;
  logic lnk_single_q;
  logic lnk_single_d;
  logic [3:0] lnk_ctrl;
  logic lnk_single;

  // Builds the full first register with its mirror bits
  function automatic logic [7:0] cfg_a_value(input logic [3:0] c);
    logic [7:0] v;
    v = {4'h0, c};
    v[POS_MIRROR_LO + 3] = c[POS_SELF_RESET];
    v[POS_MIRROR_LO + 2] = c[POS_BIT_ORDER];
    v[POS_MIRROR_LO + 1] = c[POS_ADDR_DIR];
    v[POS_MIRROR_LO] = c[POS_FOUR_WIRE];
    return v;
  endfunction

  // Read mux over the register space; unmapped reads zero
  function automatic logic [7:0] reg_read(input logic [14:0] a, input logic [3:0] c,
                                          input logic [1:0] b);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_CFG_A)
      v = cfg_a_value(c);
    else if (a == ADDR_CFG_B)
      v = {b, 6'h00};
    else if (a == ADDR_KIND)
      v = KIND_CODE_DEFAULT;
    return v;
  endfunction

  // Bit-order aware byte reversal
  function automatic logic [7:0] orient(input logic [7:0] v, input logic lsb);
    logic [7:0] r;
    r = v;
    if (lsb)
      r = {<<{v}};
    return r;
  endfunction

  assign lnk_ctrl = lnk_ctrl_q;
  assign lnk_single = lnk_single_q;

  // Next address in a stream
  function automatic logic [14:0] step_addr(input logic [14:0] a, input logic up);
    logic [14:0] r;
    r = up ? a + 15'h0001 : a - 15'h0001;
    return r;
  endfunction

  // Link-domain next state
  always_comb
  begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q + 5'h01;
    shift_d = {shift_q[14:0], SDIO_IN};
    read_d = read_q;
    addr_d = addr_q;
    tx_d = tx_q;
    wr_tog_d = wr_tog_q;
    wr_addr_d = wr_addr_q;
    wr_data_d = wr_data_q;
    lnk_ctrl_d = lnk_ctrl_q;
    lnk_single_d = lnk_single_q;
    unique case (state_q)
      LINK_HDR:
      begin
        // First rise of the frame: freeze the control bits for the frame
        if (bit_cnt_q == 5'h00)
        begin
          lnk_ctrl_d = ctrl_q;
          lnk_single_d = cfg_b_q[1];
        end
        // Header done: latch direction and start address
        if (bit_cnt_q == HDR_LAST)
        begin
          read_d = shift_q[14];
          addr_d = {shift_q[13:0], SDIO_IN};
          tx_d = orient(reg_read({shift_q[13:0], SDIO_IN}, lnk_ctrl, cfg_b_q),
                        lnk_ctrl[POS_BIT_ORDER]);
          bit_cnt_d = 5'h00;
          state_d = LINK_DATA;
        end
      end
      LINK_DATA:
      begin
        tx_d = {tx_q[6:0], 1'b0};
        if (bit_cnt_q[2:0] == BYTE_LAST)
        begin
          bit_cnt_d = 5'h00;
          if (!read_q)
          begin
            // Write data taken in the chosen bit order
            wr_data_d = orient({shift_q[6:0], SDIO_IN}, lnk_ctrl[POS_BIT_ORDER]);
            wr_addr_d = addr_q;
            wr_tog_d = ~wr_tog_q;
          end
          addr_d = step_addr(addr_q, lnk_ctrl[POS_ADDR_DIR]);
          tx_d = orient(reg_read(step_addr(addr_q, lnk_ctrl[POS_ADDR_DIR]), lnk_ctrl,
                                 cfg_b_q), lnk_ctrl[POS_BIT_ORDER]);
          // Single-transfer mode ends the frame after one byte
          if (lnk_single)
            state_d = LINK_DONE;
        end
      end
      LINK_DONE:
      begin
        // Remaining clocks in the frame are ignored
        bit_cnt_d = bit_cnt_q;
      end
      default:
      begin
        state_d = LINK_DONE;
      end
    endcase
  end

  // Link-domain registers; reset while chip select is idle
  always_ff @(posedge SCLK or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      state_q <= LINK_HDR;
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      read_q <= 1'b0;
      addr_q <= 15'h0000;
      lnk_ctrl_q <= RESET_CFG_A[3:0];
      lnk_single_q <= RESET_CFG_B[POS_SINGLE];
    end
    else
    begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      read_q <= read_d;
      addr_q <= addr_d;
      lnk_ctrl_q <= lnk_ctrl_d;
      lnk_single_q <= lnk_single_d;
    end
  end

  // Write toggle and payload survive chip select; held for the crossing
  always_ff @(posedge SCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_tog_q <= 1'b0;
      wr_addr_q <= 15'h0000;
      wr_data_q <= 8'h00;
    end
    else
    begin
      wr_tog_q <= wr_tog_d;
      wr_addr_q <= wr_addr_d;
      wr_data_q <= wr_data_d;
    end
  end

  // Read data launched on the falling edge for the host's rising edge;
  // half a period of setup at the host, bought with one negedge flop
  logic out_bit_q;
  logic out_bit_d;
  always_comb
  begin
    out_bit_d = tx_q[7];
  end
  always_ff @(negedge SCLK or negedge link_rst_n)
  begin
    if (!link_rst_n)
      out_bit_q <= 1'b0;
    else
      out_bit_q <= out_bit_d;
  end
  always_ff @(posedge SCLK or negedge link_rst_n)
  begin
    if (!link_rst_n)
      tx_q <= 8'h00;
    else
      tx_q <= tx_d;
  end

  // Output pin drive: SDO in four-wire mode, else shared SDIO
  logic driving;
  assign driving = ~CS_N & read_q & (state_q == LINK_DATA);
  assign SDIO_OUT = out_bit_q;
  assign SDO = out_bit_q;
  assign SDIO_OE = driving & ~lnk_ctrl[POS_FOUR_WIRE];
  assign SDO_OE = driving & lnk_ctrl[POS_FOUR_WIRE];

  // Write toggle crossing into CLK
  logic tog_sync;
  logic tog_seen_q;
  logic tog_seen_d;
  spi_sync_bit spi_sync_bit_i
  (
    .clk(CLK),
    .rst_n(RST_N),
    .d(wr_tog_q),
    .q(tog_sync)
  );
  logic wr_pulse;
  assign wr_pulse = tog_sync ^ tog_seen_q;

  // Register file next values and soft reset sequencing
  always_comb
  begin
    ctrl_d = ctrl_q;
    cfg_b_d = cfg_b_q;
    rst_cnt_d = rst_cnt_q;
    tog_seen_d = tog_sync;
    if (rst_cnt_q != 4'h0)
    begin
      rst_cnt_d = rst_cnt_q - 4'h1;
      // Reset done: all bits to reset value, self-reset bit clears
      if (rst_cnt_q == 4'h1)
      begin
        ctrl_d = RESET_CFG_A[3:0];
        cfg_b_d = RESET_CFG_B[7:6];
      end
    end
    else if (wr_pulse && wr_addr_q == ADDR_CFG_A)
    begin
      ctrl_d = wr_data_q[3:0];
      if (wr_data_q[POS_SELF_RESET])
        rst_cnt_d = SOFT_RESET_CNT;
    end
    else if (wr_pulse && wr_addr_q == ADDR_CFG_B)
    begin
      cfg_b_d = {wr_data_q[POS_SINGLE], wr_data_q[POS_STALL]};
    end
  end

  // Register file storage
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl_q <= RESET_CFG_A[3:0];
      cfg_b_q <= RESET_CFG_B[7:6];
      rst_cnt_q <= 4'h0;
      tog_seen_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      cfg_b_q <= cfg_b_d;
      rst_cnt_q <= rst_cnt_d;
      tog_seen_q <= tog_seen_d;
    end
  end

  // Soft reset line runs while the counter is live
  assign SOFT_RESET_ACTIVE = (rst_cnt_q != 4'h0);
endmodule

// File: rtl/spi_cfg_pkg.sv
// Constants for the serial control port: register indices, field positions,
// reset values, frame layout and the soft reset timing.
// Assumes a single 8-bit register space reached only over the serial port.
package spi_cfg_pkg;
  // Register indices (byte addresses on the serial port)
  localparam logic [14:0] ADDR_CFG_A = 15'h0000;
  localparam logic [14:0] ADDR_CFG_B = 15'h0001;
  localparam logic [14:0] ADDR_KIND = 15'h0003;
  // Field positions in the first configuration register
  localparam int POS_SELF_RESET = 0;
  localparam int POS_BIT_ORDER = 1;
  localparam int POS_ADDR_DIR = 2;
  localparam int POS_FOUR_WIRE = 3;
  localparam int POS_MIRROR_LO = 4;
  // Field positions in the second configuration register
  localparam int POS_SINGLE = 7;
  localparam int POS_STALL = 6;
  // Reset values
  localparam logic [7:0] RESET_CFG_A = 8'h00;
  localparam logic [7:0] RESET_CFG_B = 8'h00;
  // Chip kind code; value is arbitrary
  localparam logic [7:0] KIND_CODE_DEFAULT = 8'h5A;
  // Frame layout: one read flag, 15 address bits, then data bytes
  localparam int HDR_BITS = 16;
  localparam logic [4:0] HDR_LAST = 5'h0F;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  // Soft reset pulse length
  localparam int SOFT_RESET_NS = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SOFT_RESET_CYC = (SOFT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SOFT_RESET_CNT = 4'(SOFT_RESET_CYC);
  // Link states
  typedef enum logic [1:0]
  {
    LINK_HDR = 2'b00,
    LINK_DATA = 2'b01,
    LINK_DONE = 2'b10
  } link_state_t;
endpackage

// File: rtl/spi_sync_bit.sv
// Two flip-flop synchroniser for one level.
// Assumes the input is a level that holds long enough to be seen.
`timescale 1ns/1ps
module spi_sync_bit
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  // First stage, read only by the second
  logic meta_q;
  logic meta_d;
  logic sync_d;

  // Next values
  always_comb
  begin
    meta_d = d;
    sync_d = meta_q;
  end

  // Both stages
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      q <= sync_d;
    end
  end
endmodule

// File: verification/serial_port_interface_config_tb.sv
// Bench for the serial control port: random config writes over the link.
// Assumes the package and host model are compiled first.
`timescale 1ns/1ps
module serial_port_interface_config_tb;
  import spi_cfg_pkg::*;
  logic clk;
  logic rst_n;
  logic seen;
  logic [7:0] cfg_a_m; // Expected first config register
  logic [7:0] v;
  int seed;
  int err_count;
  int n_compared;
  int i;
  wire sclk, cs_n, mosi, sdio_out, sdio_oe, sdo, sdo_oe, sra;
  wire sdio = sdio_oe ? sdio_out : mosi; // Shared data wire
  wire sdo_line = sdo_oe ? sdo : ~sdo; // Released SDO shows the inverse bit
  serial_port_interface_config serial_port_interface_config_i (.CLK(clk), .RST_N(rst_n),
    .SCLK(sclk), .CS_N(cs_n), .SDIO_IN(sdio), .SDIO_OUT(sdio_out), .SDIO_OE(sdio_oe),
    .SDO(sdo), .SDO_OE(sdo_oe), .SOFT_RESET_ACTIVE(sra));
  spi_host_model spi_host_model_i (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .sdio(sdio),
    .sdo(sdo_line));
  // Expected value with mirror bits
  function automatic logic [7:0] mirror(input logic [3:0] lo);
    return {lo[0], lo[1], lo[2], lo[3], lo};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      err_count++;
    end
  endtask
  // Frames use the bit order and wire mode currently expected
  task automatic wr(input logic [14:0] a, input int n, input logic [7:0] d0,
    input logic [7:0] d1);
    spi_host_model_i.buf_q[0] = d0;
    spi_host_model_i.buf_q[1] = d1;
    spi_host_model_i.frame(1'b0, a, n, cfg_a_m[1], cfg_a_m[3]);
  endtask
  task automatic rdc(input logic [14:0] a, input int n, input logic [7:0] e0,
    input logic [7:0] e1);
    spi_host_model_i.frame(1'b1, a, n, cfg_a_m[1], cfg_a_m[3]);
    check(spi_host_model_i.buf_q[0], e0);
    if (n > 1)
      check(spi_host_model_i.buf_q[1], e1);
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Free running system clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Soft reset pulse is over before a frame returns, so latch it
  always @(posedge sra or negedge rst_n)
  begin
    if (!rst_n)
      seen <= 1'b0;
    else
      seen <= 1'b1;
  end
  // Hang guard: about twice the length of all frames together
  initial
  begin
    #400000;
    err_count++;
    end_sim();
  end
  initial
  begin
    seed = 32'h524795DE;
    err_count = 0;
    n_compared = 0;
    cfg_a_m = 8'h00;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    rdc(ADDR_KIND, 2, KIND_CODE_DEFAULT, 8'h00);
    rdc(ADDR_CFG_A, 2, RESET_CFG_A, 8'h00);
    // Random order, direction and wire mode
    for (i = 0; i < 12; i++)
    begin
      v = 8'($random(seed)) & 8'h0E;
      wr(ADDR_CFG_A, 1, v, 8'h00);
      cfg_a_m = mirror(v[3:0]);
      rdc(ADDR_CFG_B, 2, 8'h00, cfg_a_m[2] ? 8'h00 : cfg_a_m);
    end
    // Descending stream reaches the first register
    wr(ADDR_CFG_A, 1, 8'h08, 8'h00);
    cfg_a_m = mirror(4'h8);
    wr(ADDR_CFG_B, 2, 8'h00, 8'h0A);
    cfg_a_m = mirror(4'hA);
    rdc(ADDR_CFG_A, 1, cfg_a_m, 8'h00);
    // Single transfer drops the second byte
    wr(ADDR_CFG_B, 1, 8'h80, 8'h00);
    wr(ADDR_CFG_B, 2, 8'h80, 8'h00);
    rdc(ADDR_CFG_A, 1, cfg_a_m, 8'h00);
    rdc(ADDR_CFG_B, 1, 8'h80, 8'h00);
    // Soft reset restores both registers
    wr(ADDR_CFG_A, 1, 8'h09, 8'h00);
    check({6'h00, seen, sra}, 8'h02);
    cfg_a_m = 8'h00;
    rdc(ADDR_CFG_B, 2, 8'h00, 8'h00);
    end_sim();
  end
endmodule

// File: verification/spi_cfg_sva.sv
// Checker for the serial control port outputs.
// Assumes the bind below; sees only the top module ports.
`timescale 1ns/1ps
module spi_cfg_sva
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDIO_IN,
  input wire logic SDIO_OUT,
  input wire logic SDIO_OE,
  input wire logic SDO,
  input wire logic SDO_OE,
  input wire logic SOFT_RESET_ACTIVE
);
  // Every check samples on CLK, so one default clock and reset
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // Never two drivers of read data at once
  oe_exclusive_a: assert property (!(SDIO_OE && SDO_OE))
    else $error("both read outputs enabled");
  sdo_copy_a: assert property (SDO_OE |-> SDO == SDIO_OUT)
    else $error("SDO differs from read data");
  idle_release_a: assert property (CS_N && $past(CS_N) |-> !SDIO_OE)
    else $error("data line driven while deselected");
  sdo_idle_a: assert property (CS_N |-> !SDO_OE)
    else $error("SDO driven while deselected");
  // Read bit only moves on the falling serial edge
  out_stable_a: assert property (SCLK && $past(SCLK) |-> $stable(SDIO_OUT))
    else $error("read data moved while clock high");
  pulse_len_a: assert property ($rose(SOFT_RESET_ACTIVE) |-> SOFT_RESET_ACTIVE[*8] ##1
    SOFT_RESET_ACTIVE ##1 SOFT_RESET_ACTIVE ##1 !SOFT_RESET_ACTIVE)
    else $error("soft reset pulse length wrong");
  reset_clears_a: assert property ($fell(SOFT_RESET_ACTIVE) |-> !SDO_OE)
    else $error("four wire mode kept after soft reset");
endmodule
bind serial_port_interface_config spi_cfg_sva spi_cfg_sva_i (.CLK(CLK), .RST_N(RST_N),
  .SCLK(SCLK), .CS_N(CS_N), .SDIO_IN(SDIO_IN), .SDIO_OUT(SDIO_OUT), .SDIO_OE(SDIO_OE),
  .SDO(SDO), .SDO_OE(SDO_OE), .SOFT_RESET_ACTIVE(SOFT_RESET_ACTIVE));

// File: verification/spi_host_model.sv
// Serial host model: makes the link clock, select and host data.
// Assumes the bench resolves the shared data wire from the enables.
`timescale 1ns/1ps
module spi_host_model
(
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic sdio,
  input wire logic sdo
);
  logic [7:0] buf_q[4]; // Frame data bytes
  // Idle: clock stands low, deselected
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame at 160 ns per bit; released line toggles every bit
  task automatic frame(input logic rd, input logic [14:0] a, input int n, input logic lsb,
    input logic four);
    int i;
    int b;
    #3.3 cs_n = 1'b0;
    for (i = 0; i < 16 + 8 * n; i++)
    begin
      b = lsb ? (i % 8) : 7 - (i % 8);
      if (i < 16)
        mosi = (i == 0) ? rd : a[15 - i];
      else if (rd)
        mosi = ~mosi;
      else
        mosi = buf_q[(i - 16) / 8][b];
      #80 sclk = 1'b1;
      if (rd && i >= 16)
        buf_q[(i - 16) / 8][b] = four ? sdo : sdio;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    #300;
  endtask
endmodule
